// ---- design/tco_timer.sv ----
// capture/compare timer: 16-bit up_counter, capture and compare registers, one-shot pulse
// assumes: wishbone classic master on CORE_CLK; timer pins synchronous to CORE_CLK
//
// Function
// R1 - In edge clear-and-start mode a rising edge on capture_trigger_input zeroes the counter and a falling edge captures it;
//      the code captures on that rising edge itself unless reverse_phase_capture_select is set.
// R2 - The output toggles when the counter is zeroed by that rising edge and when the count equals the compare register.
// R3 - With reverse_phase_capture_select set, capture happens on the opposite edge and raises no capture_interrupt.
// R4 - A valid edge on second_timer_input always raises capture_interrupt.
// R5 - Software should mask capture_interrupt when it does not use it.
// R6 - One-shot output works only in free-running or edge clear-and-start mode with one_shot_enable set.
// R7 - A one_shot_trigger write or a valid capture_trigger_input edge restarts the counter and sends one pulse of capture minus compare.
// R8 - No new trigger may be given while a one-shot pulse is still running.
// R9 - When only the software trigger is used the capture_trigger_input level must stay constant.
// R10 - The capture_trigger_input edge must not be chosen as count clock in edge clear-and-start mode.
// R11 - At the very first start a high input with rising or both-edge selection counts as a rising edge, not on later restarts.
// R12 - The counter adds one per selected count clock and wraps from its maximum to zero.
// R13 - In a one-shot the output toggles at the compare match and again at the capture match, then rests until the next trigger.
`timescale 1ns/1ps
module tco_timer
   import tco_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic CAPTURE_TRIGGER_INPUT,
   input wire logic SECOND_TIMER_INPUT,
   output logic TIMER_OUTPUT_PIN,
   output logic IRQ
);

   // ==========================================================
   // byte-lane merge of a write into a register image
   function automatic logic [31:0] tco_merge(input logic [31:0] old, input logic [31:0] wdat,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = wdat[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // state
   logic [3:0] mode_q;
   logic ose_q;
   logic [7:0] capc_q;
   logic [15:0] cap_q, cmp_q, cnt_q;
   logic [2:0] stat_q, mask_q;
   logic out_q, armed_q, ack_q, irq_q;
   logic [3:0] presc_q;
   logic [31:0] dat_q;
   tco_os_t os_q, os_d;

   // ==========================================================
   // wishbone decode: write lands on the edge where ack is seen
   wire logic req = WB_CYC_I & WB_STB_I;
   wire logic wr_fire = req & WB_WE_I & ack_q;
   wire logic hit_mode = WB_ADR_I == TCO_OFF_MODE;
   wire logic hit_outc = WB_ADR_I == TCO_OFF_OUTC;
   wire logic hit_capc = WB_ADR_I == TCO_OFF_CAPC;
   wire logic hit_capt = WB_ADR_I == TCO_OFF_CAPT;
   wire logic hit_comp = WB_ADR_I == TCO_OFF_COMP;
   wire logic hit_count = WB_ADR_I == TCO_OFF_COUNT;
   wire logic hit_istat = WB_ADR_I == TCO_OFF_ISTAT;
   wire logic hit_imask = WB_ADR_I == TCO_OFF_IMASK;
   wire logic hit_stat = WB_ADR_I == TCO_OFF_STAT;
   wire logic [31:0] m_mode = tco_merge({28'h0, mode_q}, WB_DAT_I, WB_SEL_I);
   wire logic [31:0] m_outc = tco_merge({26'h0, ose_q, 5'h0}, WB_DAT_I, WB_SEL_I);
   wire logic [31:0] m_capc = tco_merge({24'h0, capc_q}, WB_DAT_I, WB_SEL_I);
   wire logic [31:0] m_capt = tco_merge({16'h0, cap_q}, WB_DAT_I, WB_SEL_I);
   wire logic [31:0] m_comp = tco_merge({16'h0, cmp_q}, WB_DAT_I, WB_SEL_I);
   wire logic [31:0] m_mask = tco_merge({29'h0, mask_q}, WB_DAT_I, WB_SEL_I);
   wire logic sw_trig = wr_fire & hit_outc & WB_SEL_I[0] & WB_DAT_I[TCO_OST_BIT];
   wire logic [2:0] w1c = (wr_fire & hit_istat & WB_SEL_I[0]) ? WB_DAT_I[2:0] : 3'h0;
   wire logic os_busy = os_q != TCO_OS_IDLE;

   // read selection; unmapped offsets read zero
   wire logic [31:0] rd_word =
      hit_mode ? {28'h0, mode_q} :
      hit_outc ? {26'h0, ose_q, 5'h0} :
      hit_capc ? {24'h0, capc_q} :
      hit_capt ? {16'h0, cap_q} :
      hit_comp ? {16'h0, cmp_q} :
      hit_count ? {16'h0, cnt_q} :
      hit_istat ? {29'h0, stat_q} :
      hit_imask ? {29'h0, mask_q} :
      hit_stat ? {30'h0, os_busy, out_q} : 32'h0000_0000;

   // ==========================================================
   // control fields
   wire logic [1:0] mode = mode_q[TCO_MODE_LO +: 2];
   wire logic [1:0] cks = mode_q[TCO_CKS_LO +: 2];
   wire logic run = mode != TCO_MODE_STOP;
   wire logic rev = capc_q[TCO_REV_BIT];
   wire logic os_allowed = ose_q & run & (mode == TCO_MODE_FREE | mode == TCO_MODE_EDGE_CLR); // [R6]

   // ==========================================================
   // input edges
   logic ti0_valid, ti0_opp, ti1_valid;

   tco_edge_det u_ti0 (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .pin(CAPTURE_TRIGGER_INPUT),
      .run(run),
      .armed(armed_q),
      .edge_sel(capc_q[TCO_E0_LO +: 2]),
      .valid(ti0_valid),
      .opposite(ti0_opp)
   );

   tco_edge_det u_ti1 (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .pin(SECOND_TIMER_INPUT),
      .run(run),
      .armed(armed_q),
      .edge_sel(capc_q[TCO_E1_LO +: 2]),
      .valid(ti1_valid),
      .opposite()
   );

   // ==========================================================
   // count clock and counter events
   wire logic presc_hit = (cks == TCO_CKS_CORE) |
                          (cks == TCO_CKS_DIV4 & (presc_q & TCO_DIV4_LAST) == TCO_DIV4_LAST) |
                          (cks == TCO_CKS_DIV16 & presc_q == TCO_DIV16_LAST);
   wire logic tick = run & ((cks == TCO_CKS_TI0) ? ti0_valid : presc_hit);
   wire logic at_cmp = cnt_q == cmp_q;
   wire logic at_cap = cnt_q == cap_q;
   wire logic match = tick & at_cmp;
   wire logic wrap = tick & cnt_q == TCO_CNT_MAX;
   wire logic os_trig = os_allowed & ~os_busy & (sw_trig | ti0_valid); // [R7]
   wire logic es_clr = run & mode == TCO_MODE_EDGE_CLR & ti0_valid & ~os_allowed; // [R1]
   wire logic cc_clr = match & mode == TCO_MODE_CMP_CLR;
   wire logic cap_norm = run & ~os_allowed & ti0_valid & ~rev;
   wire logic cap_rev = run & ~os_allowed & ti0_opp & rev; // [R3]
   wire logic os_tog = os_allowed & ((os_q == TCO_OS_WAIT & match) |
                                     (os_q == TCO_OS_PULSE & tick & at_cap)); // [R13]
   wire logic tog = ~os_allowed & (es_clr | match); // [R2]
   wire logic [2:0] ev = {wrap, match, cap_norm | ti1_valid}; // [R4]
   wire logic [2:0] stat_d = (stat_q & ~w1c) | ev;

   // next count: stop zeroes, any restart zeroes, otherwise step and wrap [R12]
   wire logic [15:0] cnt_d = (~run | os_trig | es_clr | cc_clr) ? TCO_RST_CNT :
                             tick ? cnt_q + 16'h0001 : cnt_q;
   wire logic [15:0] cap_d = (cap_norm | cap_rev) ? cnt_q : // [R1] [R3]
                             (wr_fire & hit_capt) ? m_capt[15:0] : cap_q;

   // one-shot sequencer: wait for compare, drive until capture, then rest [R13]
   always_comb begin
      os_d = os_q;
      case (os_q)
         TCO_OS_IDLE: begin
            if (os_trig) begin
               os_d = TCO_OS_WAIT;
            end
         end
         TCO_OS_WAIT: begin
            if (!os_allowed) begin
               os_d = TCO_OS_IDLE;
            end else if (match) begin
               os_d = TCO_OS_PULSE;
            end
         end
         TCO_OS_PULSE: begin
            if (!os_allowed || (tick && at_cap)) begin
               os_d = TCO_OS_IDLE;
            end
         end
         default: os_d = TCO_OS_IDLE;
      endcase
   end

   // ==========================================================
   // software registers
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_q <= TCO_RST_MODE;
         ose_q <= 1'b0;
         capc_q <= TCO_RST_CAPC;
         cmp_q <= TCO_RST_CNT;
         mask_q <= TCO_RST_IRQ;
      end else if (wr_fire) begin
         if (hit_mode) mode_q <= m_mode[3:0];
         if (hit_outc) ose_q <= m_outc[TCO_OSE_BIT];
         if (hit_capc) capc_q <= m_capc[7:0];
         if (hit_comp) cmp_q <= m_comp[15:0];
         if (hit_imask) mask_q <= m_mask[2:0];
      end
   end

   // timer state; a hardware event beats a same-cycle clear
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cnt_q <= TCO_RST_CNT;
         cap_q <= TCO_RST_CNT;
         stat_q <= TCO_RST_IRQ;
         presc_q <= 4'h0;
         armed_q <= 1'b0;
         out_q <= 1'b0;
         os_q <= TCO_OS_IDLE;
      end else begin
         cnt_q <= cnt_d;
         cap_q <= cap_d;
         stat_q <= stat_d;
         presc_q <= run ? presc_q + 4'h1 : 4'h0;
         armed_q <= armed_q | run; // [R11]
         out_q <= os_trig ? 1'b0 : (tog | os_tog) ? ~out_q : out_q; // [R2] [R7]
         os_q <= os_d;
      end
   end

   // bus answer: ack one cycle after the request, data sampled with it
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         irq_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
         dat_q <= (req & ~ack_q) ? rd_word : dat_q;
         irq_q <= |(stat_q & mask_q); // [R5]
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = dat_q;
   assign TIMER_OUTPUT_PIN = out_q;
   assign IRQ = irq_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   edge_clear_a: assert property (es_clr |=> cnt_q == 16'h0000) // [R1]
      else $error("edge clear did not zero the counter");
   rev_capture_a: assert property (cap_rev |=> cap_q == $past(cnt_q)) // [R3]
      else $error("reverse phase capture lost the count");
   rev_no_irq_a: assert property (cap_rev && !ti1_valid && !stat_q[0] |=> !stat_q[0]) // [R3]
      else $error("reverse phase capture raised the capture interrupt");
   second_irq_a: assert property (ti1_valid |=> stat_q[0] ##1 (irq_q || !mask_q[0])) // [R4]
      else $error("second input edge missed the capture interrupt");
   match_toggle_a: assert property (match && !os_allowed |=> out_q != $past(out_q)) // [R2]
      else $error("compare match did not toggle the output");
   os_gate_a: assert property (!os_allowed |=> os_q == TCO_OS_IDLE) // [R6]
      else $error("one-shot active while not allowed");
   os_start_a: assert property (os_trig |=> cnt_q == 16'h0000 && !out_q && os_q == TCO_OS_WAIT) // [R7]
      else $error("one-shot trigger did not restart");
   os_end_a: assert property (os_q == TCO_OS_PULSE && os_allowed && tick && at_cap
                              |=> !out_q && os_q == TCO_OS_IDLE) // [R13]
      else $error("one-shot pulse did not end at capture match");
   count_wrap_a: assert property (wrap && mode == TCO_MODE_FREE && !os_trig |=> cnt_q == 16'h0000) // [R12]
      else $error("counter did not wrap to zero");
   ack_pulse_a: assert property (req && !ack_q |=> ack_q ##1 !ack_q)
      else $error("bus ack not a single cycle");

   os_done_c: cover property (os_q == TCO_OS_PULSE ##1 os_q == TCO_OS_IDLE);
   edge_clear_c: cover property (es_clr ##[1:50] cap_rev);
   second_irq_c: cover property (ti1_valid ##2 irq_q);

endmodule

// ---- design/tco_pkg.sv ----
// package: register map, field positions, reset values and codes of the capture/compare timer
// assumes: shared by the timer top and its edge detector
package tco_pkg;

   // ==========================================================
   // register byte offsets on the wishbone slave
   localparam logic [7:0] TCO_OFF_MODE = 8'h00; // timer_mode_control
   localparam logic [7:0] TCO_OFF_OUTC = 8'h04; // timer_output_control
   localparam logic [7:0] TCO_OFF_CAPC = 8'h08; // capture_compare_control
   localparam logic [7:0] TCO_OFF_CAPT = 8'h0C; // capture_register
   localparam logic [7:0] TCO_OFF_COMP = 8'h10; // compare_register
   localparam logic [7:0] TCO_OFF_COUNT = 8'h14; // up_counter, read only
   localparam logic [7:0] TCO_OFF_ISTAT = 8'h18; // sticky events, write one to clear
   localparam logic [7:0] TCO_OFF_IMASK = 8'h1C; // interrupt enables
   localparam logic [7:0] TCO_OFF_STAT = 8'h20; // live state, read only

   // ==========================================================
   // field positions
   localparam int TCO_MODE_LO = 2;       // mode_select_low, mode_select_high above it
   localparam int TCO_CKS_LO = 0;        // count_clock_select_low, _high above it
   localparam int TCO_OSE_BIT = 5;       // one_shot_enable
   localparam int TCO_OST_BIT = 6;       // one_shot_trigger, write only
   localparam int TCO_REV_BIT = 1;       // reverse_phase_capture_select
   localparam int TCO_E0_LO = 4;         // valid edge of capture_trigger_input
   localparam int TCO_E1_LO = 6;         // valid edge of second_timer_input
   localparam int TCO_IRQ_CAP = 0;       // capture_interrupt
   localparam int TCO_IRQ_MATCH = 1;     // compare match
   localparam int TCO_IRQ_OVF = 2;       // counter wrap

   // ==========================================================
   // codes
   localparam logic [1:0] TCO_MODE_STOP = 2'h0;
   localparam logic [1:0] TCO_MODE_FREE = 2'h1;
   localparam logic [1:0] TCO_MODE_EDGE_CLR = 2'h2;
   localparam logic [1:0] TCO_MODE_CMP_CLR = 2'h3;
   localparam logic [1:0] TCO_CKS_CORE = 2'h0;
   localparam logic [1:0] TCO_CKS_DIV4 = 2'h1;
   localparam logic [1:0] TCO_CKS_DIV16 = 2'h2;
   localparam logic [1:0] TCO_CKS_TI0 = 2'h3;
   localparam logic [1:0] TCO_EDGE_FALL = 2'h0;
   localparam logic [1:0] TCO_EDGE_RISE = 2'h1;
   localparam logic [3:0] TCO_DIV4_LAST = 4'h3;
   localparam logic [3:0] TCO_DIV16_LAST = 4'hF;
   localparam logic [15:0] TCO_CNT_MAX = 16'hFFFF;

   // ==========================================================
   // reset values
   localparam logic [3:0] TCO_RST_MODE = 4'h0;
   localparam logic [7:0] TCO_RST_CAPC = 8'h50; // both inputs rising, normal capture
   localparam logic [15:0] TCO_RST_CNT = 16'h0000;
   localparam logic [2:0] TCO_RST_IRQ = 3'h0;

   typedef enum logic [2:0] {
      TCO_OS_IDLE = 3'b001,
      TCO_OS_WAIT = 3'b010,
      TCO_OS_PULSE = 3'b100
   } tco_os_t;

endpackage

// ---- design/tco_edge_det.sv ----
// edge detector for one timer input pin, with first-start rising edge behaviour
// assumes: pin is synchronous to clk; armed is high once the timer has ever run
`timescale 1ns/1ps
module tco_edge_det
   import tco_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   input wire logic run,
   input wire logic armed,
   input wire logic [1:0] edge_sel,
   output logic valid,
   output logic opposite
);

   // ==========================================================
   // previous level
   logic prev_q;
   wire logic rise = run & pin & ~prev_q;
   wire logic fall = run & ~pin & prev_q;

   // before the first start the history reads low, so a high pin counts as a rise [R11]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= (run | armed) ? pin : 1'b0; // [R11]
      end
   end

   // valid and opposite edges; with both edges chosen there is no opposite
   assign valid = (edge_sel == TCO_EDGE_FALL) ? fall :
                  (edge_sel == TCO_EDGE_RISE) ? rise : (rise | fall);
   assign opposite = (edge_sel == TCO_EDGE_FALL) ? rise :
                     (edge_sel == TCO_EDGE_RISE) ? fall : 1'b0;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   first_rise_a: assert property (!armed && run && pin && edge_sel != TCO_EDGE_FALL |-> valid) // [R11]
      else $error("high pin at first start not taken as rising edge");

endmodule

// ---- verif/tco_pin_model.sv ----
// pin model: drives both timer inputs on command and measures output pulses
// assumes: the bench calls set_pins just after a rising edge of clk
`timescale 1ns/1ps
module tco_pin_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tout,
   output logic ti0,
   output logic ti1,
   output logic [15:0] width,
   output logic [7:0] pulses
);
   logic [15:0] run_q;

   // ==========================================================
   // input drive
   // levels change only when commanded, never on their own
   task automatic set_pins(input logic a, input logic b);
      ti0 <= a;
      ti1 <= b;
   endtask

   // ==========================================================
   // load side
   // counts the high time of each output pulse in clock cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= 16'h0;
         width <= 16'h0;
         pulses <= 8'h0;
      end else if (tout === 1'b1) begin
         run_q <= run_q + 16'h1;
      end else if (run_q != 16'h0) begin
         width <= run_q;
         pulses <= pulses + 8'h1;
         run_q <= 16'h0;
      end
   end
endmodule

// ---- verif/testbench.sv ----
// testbench: wishbone master tasks and one task per scenario of the timer
// assumes: tco_pkg, tco_timer and tco_pin_model are compiled before it
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("Error at %0t got %h exp %h", $time, g, e); end end
module testbench
   import tco_pkg::*;
;
   logic clk, rst_n, cyc, stb, we, ack, tout, irq, ti0, ti1;
   logic [7:0] adr, pulses;
   logic [3:0] sel;
   logic [31:0] dat_i, dat_o, q, q1;
   logic [15:0] width;
   int n_fail = 0;
   int comparisons = 0;

   // ==========================================================
   // design and far side
   tco_timer tco_timer_inst (.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .CAPTURE_TRIGGER_INPUT(ti0), .SECOND_TIMER_INPUT(ti1),
      .TIMER_OUTPUT_PIN(tout), .IRQ(irq));
   tco_pin_model tco_pin_model_inst (.clk(clk), .rst_n(rst_n), .tout(tout), .ti0(ti0),
      .ti1(ti1), .width(width), .pulses(pulses));

   // ==========================================================
   // bus tasks
   // one classic cycle: hold until ack is seen, release at that edge
   task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat_i <= d;
      // wait for the rising edge at which ack is sampled high; read data is taken there
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         test_done();
      end
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb_io(1'b1, a, d);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // mode word, always on the core clock, never the input edge
   function automatic logic [31:0] md(input logic [1:0] m);
      return {28'h0, m, TCO_CKS_CORE};
   endfunction
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      logic [7:0] offs [6] = '{TCO_OFF_MODE, TCO_OFF_CAPC, TCO_OFF_COUNT, TCO_OFF_ISTAT,
         TCO_OFF_IMASK, 8'h24};
      logic [31:0] exps [6] = '{32'h0, 32'h50, 32'h0, 32'h0, 32'h0, 32'h0};
      `CHK(tout, 1'b0)
      `CHK(irq, 1'b0)
      for (int i = 0; i < 6; i++) begin
         wb_io(1'b0, offs[i], 32'h0);
         `CHK(q, exps[i])
      end
      $display("test reset done");
   endtask
   task automatic t_first_start;
      wr(TCO_OFF_COMP, 32'hFFFF);
      tco_pin_model_inst.set_pins(1'b1, 1'b0);
      tick(3);
      wr(TCO_OFF_MODE, md(TCO_MODE_EDGE_CLR));
      tick(5);
      `CHK(tout, 1'b1)
      wr(TCO_OFF_MODE, md(TCO_MODE_STOP));
      wr(TCO_OFF_MODE, md(TCO_MODE_EDGE_CLR));
      tick(5);
      `CHK(tout, 1'b1)
      $display("test first start done");
   endtask
   task automatic t_edge_clear;
      logic o;
      wr(TCO_OFF_MODE, md(TCO_MODE_STOP));
      tco_pin_model_inst.set_pins(1'b0, 1'b0);
      wr(TCO_OFF_CAPC, 32'h52);
      wr(TCO_OFF_ISTAT, 32'h7);
      wr(TCO_OFF_MODE, md(TCO_MODE_EDGE_CLR));
      tick(4);
      o = tout;
      tco_pin_model_inst.set_pins(1'b1, 1'b0);
      tick(4);
      `CHK(tout, ~o)
      tick(10);
      tco_pin_model_inst.set_pins(1'b0, 1'b0);
      tick(4);
      wb_io(1'b0, TCO_OFF_CAPT, 32'h0);
      `CHK(q, 32'hD)
      wb_io(1'b0, TCO_OFF_ISTAT, 32'h0);
      `CHK(q[TCO_IRQ_CAP], 1'b0)
      $display("test edge clear done");
   endtask
   task automatic t_irq;
      tco_pin_model_inst.set_pins(1'b0, 1'b1);
      tick(4);
      tco_pin_model_inst.set_pins(1'b0, 1'b0);
      wb_io(1'b0, TCO_OFF_ISTAT, 32'h0);
      `CHK(q[TCO_IRQ_CAP], 1'b1)
      `CHK(irq, 1'b0)
      wr(TCO_OFF_IMASK, 32'h1);
      tick(3);
      `CHK(irq, 1'b1)
      wr(TCO_OFF_ISTAT, 32'h1);
      tick(3);
      `CHK(irq, 1'b0)
      $display("test interrupt done");
   endtask
   task automatic t_count;
      wr(TCO_OFF_MODE, md(TCO_MODE_STOP));
      wr(TCO_OFF_MODE, md(TCO_MODE_FREE));
      wb_io(1'b0, TCO_OFF_COUNT, 32'h0);
      q1 = q;
      wb_io(1'b0, TCO_OFF_COUNT, 32'h0);
      `CHK(q - q1, 32'h3)
      $display("test count done");
   endtask
   task automatic t_one_shot;
      logic [7:0] p0;
      wr(TCO_OFF_COMP, 32'h2);
      wr(TCO_OFF_CAPT, 32'h5);
      wr(TCO_OFF_OUTC, 32'h20);
      wr(TCO_OFF_OUTC, 32'h60);
      tick(12);
      `CHK(width, 16'h3)
      `CHK(tout, 1'b0)
      p0 = pulses;
      // retrigger only once the previous pulse has ended
      wr(TCO_OFF_OUTC, 32'h60);
      tick(12);
      `CHK(pulses, p0 + 8'h1)
      `CHK(width, 16'h3)
      tco_pin_model_inst.set_pins(1'b1, 1'b0);
      tick(14);
      `CHK(pulses, p0 + 8'h2)
      wr(TCO_OFF_MODE, md(TCO_MODE_CMP_CLR));
      wr(TCO_OFF_OUTC, 32'h60);
      wb_io(1'b0, TCO_OFF_STAT, 32'h0);
      `CHK(q[1], 1'b0)
      $display("test one shot done");
   endtask
   task automatic t_wrap;
      wr(TCO_OFF_MODE, md(TCO_MODE_STOP));
      wr(TCO_OFF_OUTC, 32'h0);
      wr(TCO_OFF_COMP, 32'hFFFF);
      wr(TCO_OFF_ISTAT, 32'h7);
      wr(TCO_OFF_MODE, md(TCO_MODE_FREE));
      tick(65540);
      wb_io(1'b0, TCO_OFF_ISTAT, 32'h0);
      `CHK(q[TCO_IRQ_OVF], 1'b1)
      $display("test wrap done");
   endtask

   // ==========================================================
   // clock, reset, sequence and watchdog
   // free running core clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // reset for 8 cycles, then the scenarios in order
   initial begin
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h0;
      sel = 4'hF;
      dat_i = 32'h0;
      tco_pin_model_inst.set_pins(1'b0, 1'b0);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_first_start();
      t_edge_clear();
      t_irq();
      t_count();
      t_one_shot();
      t_wrap();
      test_done();
   end
   // cuts a hang short well beyond the expected run
   initial begin
      repeat (90000) @(posedge clk);
      n_fail++;
      test_done();
   end
endmodule
